// file: verilog/fsrb_bank.sv
// status register bank with apb slave and protection decode
// What this block does
// - software and chip select resets copy nonvolatile bits into volatile; hardware reset loads both with the factory default
// - nonvolatile write also loads the volatile copy
// - volatile write leaves nonvolatile copy alone
// - lock bit with protect pin low blocks writes in single line mode
// - failed program sets program failure flag
// - program failure flag holds until clear or reset
// - failed or protected erase sets erase failure flag
// - erase failure flag holds until clear or reset
// - failure flag keeps busy set, blocking latch commands, register writes and operation start
// - failure flags set only at operation start or done
// - decode protect size field into sector range
// - permanent lock freezes nonvolatile protect size; volatile copy can only be reloaded from it
// - protect from top or from bottom
// - no program, erase or write without latch
// - write enable commands set the latch
// - write disable command clears the latch
// - successful operation clears the latch
// - power-up and resets clear the latch
// - busy flag shows embedded operation running
// - erase ok flag reflects evaluated sector
// - erase suspended flag while erase suspended
// - program suspended flag while program suspended
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fsrb_bank
    import fsrb_pkg::*;
#(
    parameter int SECTORS = SECTORS_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic write_protect_b_i,
    input wire logic single_line_mode_i,
    input wire logic permanent_lock_i,
    input wire logic protect_from_bottom_i,
    input wire logic [7:0] op_sector_i,
    output logic busy_flag_o,
    output logic op_allowed_o,
    output logic sector_protected_o
);

    localparam int SW = $clog2(SECTORS);

    initial
    begin
        if (SECTORS < 16 || (SECTORS & (SECTORS - 1)) != 0 || SW > 8)
            $error("fsrb_bank: SECTORS must be a power of two, 16..256");
    end

    typedef struct packed {
        logic [7:0] stat1_nv;
        logic status_write_lock_en;
        logic program_fail_flag;
        logic erase_fail_flag;
        logic [2:0] block_protect_size;
        logic write_enable_latch;
        logic op_running;
        logic op_is_erase;
        logic sector_erase_ok;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic [7:0] op_sector;
        logic [31:0] rdata;
        logic pready;
        logic pslverr;
    } fsrb_state_type;

    fsrb_state_type s_q;
    fsrb_state_type s_d;

    logic wr_acc;
    logic rd_acc;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic busy;
    logic reg_lock;
    logic [7:0] vol_image;
    logic [7:0] st2_image;
    logic prot;
    logic [8:0] lim;
    logic [7:0] sec_rel;

    ////////////////////////////////////////////////////////////////////
    // apb decode helpers
    assign wr_acc = psel_i && penable_i && pwrite_i && !s_q.pready;
    assign rd_acc = psel_i && penable_i && !pwrite_i && !s_q.pready;
    assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}},
                    {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign wd = pwdata_i & wmask;

    // busy while an operation runs or a failure is pending
    assign busy = s_q.op_running || s_q.program_fail_flag
        || s_q.erase_fail_flag;

    // lock bit with protect pin low in single line mode
    assign reg_lock = s_q.status_write_lock_en && !write_protect_b_i
        && single_line_mode_i;

    // volatile images as read back
    assign vol_image = {s_q.status_write_lock_en, s_q.program_fail_flag,
                        s_q.erase_fail_flag, s_q.block_protect_size,
                        s_q.write_enable_latch, busy};
    assign st2_image = {5'h00, s_q.sector_erase_ok,
                        s_q.erase_suspended_flag,
                        s_q.program_suspended_flag};

    ////////////////////////////////////////////////////////////////////
    // protected sector range decode
    always_comb
    begin
        case (s_q.block_protect_size)
            BPS_NONE: lim = 9'h000;
            BPS_FOUR: lim = 9'h004;
            BPS_EIGHT: lim = 9'h008;
            BPS_ALL_BUT_TWO: lim = 9'(SECTORS - 2);
            default: lim = 9'h004 << s_q.block_protect_size;
        endcase
        if (lim > 9'(SECTORS - 2))
            lim = 9'(SECTORS - 2);
        // distance from the protected end of the array
        if (protect_from_bottom_i)
            sec_rel = op_sector_i;
        else
            sec_rel = 8'(9'(SECTORS - 1) - {1'b0, op_sector_i});
        prot = {1'b0, sec_rel} < lim;
    end

    assign sector_protected_o = prot;
    // program or erase may start only with latch and no busy
    assign op_allowed_o = s_q.write_enable_latch && !busy;
    assign busy_flag_o = busy;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [7:0] nv_new;
        logic [7:0] v_new;
        logic [7:0] keep;
        nv_new = 8'h00;
        v_new = 8'h00;
        keep = 8'h00;
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // frozen fields under permanent lock
        keep = permanent_lock_i ? 8'h1C : 8'h00;

        if (wr_acc || rd_acc)
        begin
            s_d.pready = 1'b1;
        end

        // read path
        if (rd_acc)
        begin
            if (paddr_i == ADDR_STAT1)
                s_d.rdata = {24'h0, vol_image};
            else if (paddr_i == ADDR_STAT2)
                s_d.rdata = {24'h0, st2_image};
            else if (paddr_i == ADDR_STAT1_NV)
                s_d.rdata = {24'h0, s_q.stat1_nv};
            else if (paddr_i == ADDR_CFG)
                s_d.rdata = {24'h0, 5'h00, single_line_mode_i,
                             write_protect_b_i, reg_lock};
            else if (paddr_i == ADDR_PROT)
                s_d.rdata = {24'h0, 6'h00, op_allowed_o, prot};
            else
            begin
                s_d.rdata = UNMAPPED_READ;
                s_d.pslverr = 1'b1;
            end
        end

        // embedded operation events from the core
        if (wr_acc && paddr_i == ADDR_EVENT)
        begin
            if (wd[EV_START] && op_allowed_o)
            begin
                s_d.op_running = 1'b1;
                s_d.op_is_erase = wd[EV_IS_ERASE];
                s_d.op_sector = op_sector_i;
                // protected target fails at once
                if (prot && wd[EV_IS_ERASE])
                    s_d.erase_fail_flag = 1'b1;
                else if (prot)
                    s_d.program_fail_flag = 1'b1;
                if (prot)
                    s_d.op_running = 1'b0;
            end
            if (wd[EV_DONE] && s_q.op_running)
            begin
                s_d.op_running = 1'b0;
                if (wd[EV_FAIL] && s_q.op_is_erase)
                    s_d.erase_fail_flag = 1'b1;
                else if (wd[EV_FAIL])
                    s_d.program_fail_flag = 1'b1;
                else
                    s_d.write_enable_latch = 1'b0;
            end
            if (wd[EV_ESUS] && s_q.op_running && s_q.op_is_erase)
                s_d.erase_suspended_flag = 1'b1;
            if (wd[EV_PSUS] && s_q.op_running && !s_q.op_is_erase)
                s_d.program_suspended_flag = 1'b1;
            if (wd[EV_RESUME] || wd[EV_DONE])
            begin
                s_d.erase_suspended_flag = 1'b0;
                s_d.program_suspended_flag = 1'b0;
            end
            if (wd[EV_EVAL] && !busy)
                s_d.sector_erase_ok = wd[EV_EVAL_OK];
        end

        // host commands
        if (wr_acc && paddr_i == ADDR_CMD)
        begin
            if (!busy && (wd[CMD_WREN] || wd[CMD_WRVOL]))
                s_d.write_enable_latch = 1'b1;
            if (!busy && wd[CMD_WRDI])
                s_d.write_enable_latch = 1'b0;
            // clear failure flags, set of this cycle does not apply
            if (wd[CMD_CLRF])
            begin
                s_d.program_fail_flag = 1'b0;
                s_d.erase_fail_flag = 1'b0;
            end
            // register write: latch needed, lock honoured
            if ((wd[CMD_WRNV] || wd[CMD_WRVOL]) && !busy
                && s_q.write_enable_latch && !reg_lock)
            begin
                v_new = (wd[15:8] & STAT1_NV_MASK & ~keep)
                    | (vol_image & keep);
                if (wd[CMD_WRNV])
                begin
                    nv_new = (wd[15:8] & STAT1_NV_MASK & ~keep)
                        | (s_q.stat1_nv & keep);
                    s_d.stat1_nv = nv_new;
                    v_new = nv_new;
                end
                // volatile only: stat1_nv untouched
                s_d.status_write_lock_en = v_new[LOCK_BIT];
                s_d.block_protect_size = v_new[BPS_LSB +: 3];
                s_d.write_enable_latch = 1'b0;
            end
            // software or chip select reset reload
            if (wd[CMD_SWRST] || wd[CMD_CSRST])
            begin
                s_d.status_write_lock_en = s_q.stat1_nv[LOCK_BIT];
                s_d.block_protect_size = s_q.stat1_nv[BPS_LSB +: 3];
                s_d.program_fail_flag = 1'b0;
                s_d.erase_fail_flag = 1'b0;
                s_d.write_enable_latch = 1'b0;
                s_d.op_running = 1'b0;
                s_d.erase_suspended_flag = 1'b0;
                s_d.program_suspended_flag = 1'b0;
                s_d.sector_erase_ok = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register; reset loads volatile from factory nonvolatile
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.stat1_nv <= STAT1_NV_RESET;
            s_q.status_write_lock_en <= STAT1_NV_RESET[LOCK_BIT];
            s_q.block_protect_size <= STAT1_NV_RESET[BPS_LSB +: 3];
            s_q.write_enable_latch <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // bus outputs
    assign prdata_o = s_q.rdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;

endmodule : fsrb_bank
`default_nettype wire

// file: verilog/fsrb_pkg.sv
// constants for the flash status register bank
package fsrb_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_STAT1 = 8'h00;
    localparam logic [7:0] ADDR_STAT2 = 8'h04;
    localparam logic [7:0] ADDR_STAT1_NV = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_EVENT = 8'h10;
    localparam logic [7:0] ADDR_CFG = 8'h14;
    localparam logic [7:0] ADDR_PROT = 8'h18;
    // status one field positions
    localparam int LOCK_BIT = 7;
    localparam int PFAIL_BIT = 6;
    localparam int EFAIL_BIT = 5;
    localparam int BPS_LSB = 2;
    localparam int WEL_BIT = 1;
    localparam int BUSY_BIT = 0;
    // status two field positions
    localparam int SEOK_BIT = 2;
    localparam int ESUS_BIT = 1;
    localparam int PSUS_BIT = 0;
    // nonvolatile factory default and writable mask of status one
    localparam logic [7:0] STAT1_NV_RESET = 8'h00;
    localparam logic [7:0] STAT1_NV_MASK = 8'h9C;
    // command register bit positions (write one to issue)
    localparam int CMD_WREN = 0;
    localparam int CMD_WRDI = 1;
    localparam int CMD_CLRF = 2;
    localparam int CMD_SWRST = 3;
    localparam int CMD_WRNV = 4;
    localparam int CMD_WRVOL = 5;
    localparam int CMD_CSRST = 6;
    // event register bit positions
    localparam int EV_START = 0;
    localparam int EV_DONE = 1;
    localparam int EV_IS_ERASE = 2;
    localparam int EV_FAIL = 3;
    localparam int EV_ESUS = 4;
    localparam int EV_PSUS = 5;
    localparam int EV_RESUME = 6;
    localparam int EV_EVAL = 7;
    localparam int EV_EVAL_OK = 8;
    // block protect size codes
    localparam logic [2:0] BPS_NONE = 3'h0;
    localparam logic [2:0] BPS_FOUR = 3'h1;
    localparam logic [2:0] BPS_EIGHT = 3'h2;
    localparam logic [2:0] BPS_ALL_BUT_TWO = 3'h7;
    localparam int SECTORS_DEFAULT = 256;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : fsrb_pkg

// file: tb/fsrb_host.sv
// apb host model issuing register transfers
`timescale 1ns/100ps
`default_nettype none
module fsrb_host (
    input wire logic sys_clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    // idle bus at time zero
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'hFF;
        pwdata_o = 32'h0;
    end
    ////////////////////////////////////////
    // setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        // only the bench watchdog ends a wait that never gets an answer
        do
        begin
            @(posedge sys_clk_i);
        end
        while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a; // released lines stop showing old values
        pwdata_o <= ~d;
    endtask : xfer
endmodule : fsrb_host
`default_nettype wire

// file: tb/fsrb_bank_sva.sv
// port assertions of the status register bank
`timescale 1ns/100ps
`default_nettype none
module fsrb_bank_sva
    import fsrb_pkg::*;
#(
    parameter int SECTORS = SECTORS_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic busy_flag_o,
    input wire logic op_allowed_o,
    input wire logic sector_protected_o
);
    // all checks on the bus clock, off during reset
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////
    AST_RDY_WAIT: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access not answered after one wait state");
    AST_RDY_PULSE: assert property (
        pready_o |=> !pready_o) else $error("pready longer than one cycle");
    AST_ERR_UNMAP: assert property (
        pready_o && !$past(pwrite_i) && $past(paddr_i) > ADDR_PROT
        |-> pslverr_o && prdata_o == UNMAPPED_READ)
        else $error("unmapped read not refused");
    AST_ERR_MAPPED: assert property (
        pready_o && ($past(pwrite_i) || $past(paddr_i) == ADDR_STAT1
        || $past(paddr_i) == ADDR_STAT2 || $past(paddr_i) == ADDR_STAT1_NV
        || $past(paddr_i) == ADDR_CFG || $past(paddr_i) == ADDR_PROT)
        |-> !pslverr_o)
        else $error("error on mapped access");
    AST_STAT2_RSV: assert property (
        pready_o && !$past(pwrite_i) && $past(paddr_i) == ADDR_STAT2
        |-> prdata_o[31:3] == 29'h0) else $error("reserved bits not zero");
    AST_BUSY_READ: assert property (
        pready_o && !$past(pwrite_i) && $past(paddr_i) == ADDR_STAT1
        |-> prdata_o[0] == $past(busy_flag_o))
        else $error("busy bit differs from busy output");
    AST_FAIL_BUSY: assert property (
        pready_o && !$past(pwrite_i) && $past(paddr_i) == ADDR_STAT1
        && (prdata_o[6] || prdata_o[5]) |-> prdata_o[0])
        else $error("failure flag without busy");
    AST_PROT_READ: assert property (
        pready_o && !$past(pwrite_i) && $past(paddr_i) == ADDR_PROT
        |-> prdata_o[1:0] == {$past(op_allowed_o), $past(sector_protected_o)})
        else $error("protect readback differs from outputs");
    AST_ALLOW: assert property (
        op_allowed_o |-> !busy_flag_o) else $error("op allowed while busy");
endmodule : fsrb_bank_sva
bind fsrb_bank fsrb_bank_sva #(.SECTORS(SECTORS)) i_fsrb_bank_sva (.*);
`default_nettype wire

// file: tb/flash_status_register_bank_tb.sv
// self-checking bench of the status register bank
`timescale 1ns/100ps
`default_nettype none
module flash_status_register_bank_tb
    import fsrb_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wp_b = 1'b1;
    logic single = 1'b1;
    logic plock = 1'b0;
    logic bottom = 1'b0;
    logic [7:0] sector = 8'h00;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [19:0] tbl [7] = '{20'h00FF0, 20'h10FC1, 20'h10FB0, 20'h11031,
        20'h11040, 20'h20F70, 20'h70FD1};
    logic [15:0] rc [2] = '{16'h40, 16'h08};
    int bad_count = 0;
    int n_compared = 0;
`define CK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
bad_count++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
    // clock
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    fsrb_bank i_fsrb_bank (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .write_protect_b_i(wp_b), .single_line_mode_i(single),
        .permanent_lock_i(plock), .protect_from_bottom_i(bottom),
        .op_sector_i(sector), .busy_flag_o(), .op_allowed_o(),
        .sector_protected_o());
    fsrb_host i_fsrb_host (.sys_clk_i(sys_clk), .pready_i(pready),
        .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));
    ////////////////////////////////////////
    // command, event and masked read transfers
    task automatic cm(input logic [15:0] d);
        i_fsrb_host.xfer(1'b1, ADDR_CMD, {16'h0, d}, q, e);
    endtask : cm
    task automatic ev(input logic [15:0] d);
        i_fsrb_host.xfer(1'b1, ADDR_EVENT, {16'h0, d}, q, e);
    endtask : ev
    task automatic rd(input logic [7:0] a, m, ex);
        i_fsrb_host.xfer(1'b0, a, 32'h0, q, e);
        `CK($sformatf("reg%h", a), {24'h0, ex}, q & {24'hFFFFFF, m})
    endtask : rd
    // write enable then volatile write of status one
    task automatic vol(input logic [7:0] v);
        cm(16'h01);
        cm({v, 8'h20});
    endtask : vol
    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ADDR_STAT1, 8'hFF, 8'h00);
        rd(8'h1C, 8'hFF, 8'h00);
        `CK("slverr", 1'b1, e)
        cm(16'h01);
        rd(ADDR_STAT1, 8'hFF, 8'h02);
        cm(16'h02);
        cm(16'h0C10);
        rd(ADDR_STAT1_NV, 8'hFF, 8'h00);
        cm(16'h01);
        cm(16'h0C10);
        rd(ADDR_STAT1_NV, 8'hFF, 8'h0C);
        rd(ADDR_STAT1, 8'hFF, 8'h0C);
        vol(8'h04);
        rd(ADDR_STAT1, 8'hFF, 8'h04);
        rd(ADDR_STAT1_NV, 8'hFF, 8'h0C);
        foreach (rc[i])
        begin
            cm(rc[i]);
            rd(ADDR_STAT1, 8'hFF, 8'h0C);
            vol(8'h04);
        end
        @(posedge sys_clk);
        plock <= 1'b1;
        vol(8'h10);
        rd(ADDR_STAT1, 8'h1C, 8'h04);
        @(posedge sys_clk);
        plock <= 1'b0;
        vol(8'h80);
        @(posedge sys_clk);
        wp_b <= 1'b0;
        vol(8'h00);
        rd(ADDR_STAT1, 8'hFC, 8'h80);
        @(posedge sys_clk);
        single <= 1'b0;
        vol(8'h00);
        rd(ADDR_STAT1, 8'hFF, 8'h00);
        @(posedge sys_clk);
        single <= 1'b1;
        wp_b <= 1'b1;
        vol(8'h00);
        rd(ADDR_STAT1, 8'hFF, 8'h00);
        foreach (tbl[i])
        begin
            vol({3'h0, tbl[i][18:16], 2'h0});
            @(posedge sys_clk);
            bottom <= tbl[i][12];
            sector <= tbl[i][11:4];
            rd(ADDR_PROT, 8'h01, {7'h0, tbl[i][0]});
        end
        vol(8'h04);
        @(posedge sys_clk);
        sector <= 8'h0A;
        ev(16'h01);
        rd(ADDR_STAT1, 8'hFF, 8'h04);
        cm(16'h01);
        ev(16'h01);
        rd(ADDR_STAT1, 8'hF1, 8'h01);
        ev(16'h20);
        rd(ADDR_STAT2, 8'hFF, 8'h01);
        ev(16'h40);
        ev(16'h02);
        rd(ADDR_STAT1, 8'hFF, 8'h04);
        cm(16'h01);
        ev(16'h05);
        ev(16'h10);
        rd(ADDR_STAT2, 8'hFF, 8'h02);
        ev(16'h40);
        ev(16'h08);
        ev(16'h0A);
        rd(ADDR_STAT1, 8'hF1, 8'h21);
        cm(16'h04);
        rd(ADDR_STAT1, 8'hF1, 8'h00);
        @(posedge sys_clk);
        sector <= 8'hFD;
        cm(16'h01);
        ev(16'h01);
        rd(ADDR_STAT1, 8'hF1, 8'h41);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ADDR_STAT1, 8'hE3, 8'h00);
        ev(16'h08);
        rd(ADDR_STAT1, 8'hE3, 8'h00);
        ev(16'h180);
        rd(ADDR_STAT2, 8'hFF, 8'h04);
        ev(16'h80);
        rd(ADDR_STAT2, 8'hFF, 8'h00);
        stop_test();
    end
    // watchdog cuts a hung run short
    initial
    begin
        #40000;
        bad_count++;
        stop_test();
    end
endmodule : flash_status_register_bank_tb
`default_nettype wire
